/* src/sfp_pin_if.sv */
/*
 * Pin-level front end of a serial NOR flash: chip-select framing, lane
 * sampling and shifting in single, dual and quad width, pause and write
 * protect pins. Link logic runs on the host serial clock; the core side
 * runs on i_clk. Assumes a command decoder on the core side that sets
 * lane width and drive direction, and an outside pad model that resolves
 * the lane wires from o_lane_out and o_lane_oe.
 */
// Operation
// - Single width samples input lane on rising edge
// - Single width read data changes on falling edge
// - Lanes zero and one bidirectional in dual, quad
// - Standard and dual use lanes 0-1, quad 0-3
// - Select high floats all data outputs
// - Select low enables command intake and read data
// - Ignore commands until first select fall after power-up
// - Internal cycles continue after select returns high
// - Protect pin blocks status writes, arms array protection
// - Quad mode turns protect pin into lane two
// - Pause low floats output, ignores clock and input
// - Pause high resumes exactly where it stopped
// - Quad enable disables pause, pin becomes lane three
`timescale 1ns/10ps

module sfp_pin_if (
   input wire logic i_clk,
   input wire logic i_reset,
   input wire logic i_ce,
   input wire logic i_sclk,
   input wire logic i_cs_n,
   input wire logic [3:0] i_lane_in,
   output logic [3:0] o_lane_out,
   output logic [3:0] o_lane_oe,
   input sfp_pkg::sfp_lane_mode_t i_lane_mode,
   input wire logic i_drive,
   input wire logic i_quad_enable_bit,
   input wire logic [1:0] i_status_protect_bits,
   input wire logic [7:0] i_tx_byte,
   input wire logic i_tx_load,
   output logic o_tx_take,
   output logic o_rx_valid,
   output logic [7:0] o_rx_byte,
   output logic o_frame_start,
   output logic o_frame_end,
   output logic o_selected,
   output logic o_paused,
   output logic o_status_write_block,
   output logic o_hw_protect_active
);

   // Link side: cleared whenever select is high, except rx_buf_q and the toggles, which clear only on i_reset
   logic link_rst;
   sfp_pkg::sfp_lane_mode_t mode_m_q, mode_q, width_q, cur_w;
   logic qe_m_q, qe_q;
   logic drv_m_q, drv_q;
   logic hold_now, hold_q;
   logic [2:0] rx_cnt_q;
   logic [7:0] rx_sr_q, rx_sr_d;
   logic [3:0] rx_sum;
   logic [3:0] step_rx;
   logic [7:0] rx_buf_q [2];
   logic rx_tgl_q;
   logic [2:0] tx_cnt_q;
   logic [7:0] tx_sr_q, tx_data;
   logic [3:0] tx_sum;
   logic [3:0] step_tx;
   logic tx_wait;
   logic take_tgl_q;

   // Core side
   logic cs_m_q, cs_q, cs_prev_q;
   logic wp_m_q, wp_q;
   logic pause_m_q, pause_q;
   logic rxt_m_q, rxt_q, rx_seen_q;
   logic tkt_m_q, tkt_q, tk_seen_q;
   logic armed_q, frame_ok_q;
   logic [7:0] tx_word_q;
   logic cs_fall, cs_rise;

   function automatic logic [3:0] step_of(sfp_pkg::sfp_lane_mode_t m);
      unique case (m)
         sfp_pkg::SFP_QUAD: step_of = sfp_pkg::SFP_STEP_QUAD;
         sfp_pkg::SFP_DUAL: step_of = sfp_pkg::SFP_STEP_DUAL;
         sfp_pkg::SFP_SINGLE: step_of = sfp_pkg::SFP_STEP_SINGLE;
         default: step_of = sfp_pkg::SFP_STEP_SINGLE;
      endcase
   endfunction : step_of

   assign link_rst = i_reset | i_cs_n;

   // Width and direction come from the core; two sclk edges of latency,
   // so the first edges of a frame always run single width
   always_ff @(posedge i_sclk or posedge link_rst) begin
      if (link_rst) begin
         mode_m_q <= sfp_pkg::SFP_SINGLE;
         mode_q <= sfp_pkg::SFP_SINGLE;
         qe_m_q <= 1'b0;
         qe_q <= 1'b0;
         drv_m_q <= 1'b0;
         drv_q <= 1'b0;
      end else begin
         mode_m_q <= i_lane_mode;
         mode_q <= mode_m_q;
         qe_m_q <= i_quad_enable_bit;
         qe_q <= qe_m_q;
         drv_m_q <= i_drive;
         drv_q <= drv_m_q;
      end
   end

   // Pause pin is a link pin, sampled on the same edge as data
   assign hold_now = ~qe_q & ~i_lane_in[sfp_pkg::SFP_LANE_PAUSE];

   // Width may only change on a byte boundary; quad needs quad enable
   always_comb begin
      if (rx_cnt_q != sfp_pkg::SFP_CNT_RST) begin
         cur_w = width_q;
      end else if (mode_q == sfp_pkg::SFP_QUAD && !qe_q) begin
         cur_w = sfp_pkg::SFP_DUAL;
      end else begin
         cur_w = mode_q;
      end
   end

   assign step_rx = step_of(cur_w);
   assign rx_sum = {1'b0, rx_cnt_q} + step_rx;

   always_comb begin
      unique case (cur_w)
         sfp_pkg::SFP_QUAD: rx_sr_d = {rx_sr_q[3:0], i_lane_in};
         sfp_pkg::SFP_DUAL: rx_sr_d = {rx_sr_q[5:0], i_lane_in[1:0]};
         sfp_pkg::SFP_SINGLE: rx_sr_d = {rx_sr_q[6:0], i_lane_in[0]};
         default: rx_sr_d = rx_sr_q;
      endcase
   end

   // Receive shifter; frozen while paused so it resumes in place
   always_ff @(posedge i_sclk or posedge link_rst) begin
      if (link_rst) begin
         rx_cnt_q <= sfp_pkg::SFP_CNT_RST;
         rx_sr_q <= sfp_pkg::SFP_BYTE_RST;
         width_q <= sfp_pkg::SFP_SINGLE;
         hold_q <= 1'b0;
      end else begin
         hold_q <= hold_now;
         if (!hold_now) begin
            width_q <= cur_w;
            rx_sr_q <= rx_sr_d;
            rx_cnt_q <= rx_sum[2:0];
         end
      end
   end

   // Ping-pong byte buffer survives select so the core never misses one
   always_ff @(posedge i_sclk or posedge i_reset) begin
      if (i_reset) begin
         rx_tgl_q <= 1'b0;
         rx_buf_q[0] <= sfp_pkg::SFP_BYTE_RST;
         rx_buf_q[1] <= sfp_pkg::SFP_BYTE_RST;
      end else if (!i_cs_n && !hold_now && rx_sum[3]) begin
         rx_buf_q[rx_tgl_q] <= rx_sr_d;
         rx_tgl_q <= ~rx_tgl_q;
      end
   end

   // Send width follows the width the receiver uses for the same byte
   assign step_tx = step_of(cur_w);
   // A new send byte waits for the receive byte boundary, so a drive
   // request that lands mid-byte never shifts a misaligned byte
   assign tx_wait = (tx_cnt_q == sfp_pkg::SFP_CNT_RST) &&
                    (rx_cnt_q != sfp_pkg::SFP_CNT_RST);
   assign tx_sum = {1'b0, tx_cnt_q} + step_tx;
   // tx_word_q is stable by handshake while the link reads it
   assign tx_data = (tx_cnt_q == sfp_pkg::SFP_CNT_RST) ? tx_word_q : tx_sr_q;

   // Transmit shifter on the falling edge
   always_ff @(negedge i_sclk or posedge link_rst) begin
      if (link_rst) begin
         tx_cnt_q <= sfp_pkg::SFP_CNT_RST;
         tx_sr_q <= sfp_pkg::SFP_BYTE_RST;
         o_lane_out <= sfp_pkg::SFP_LANE_RST;
         o_lane_oe <= sfp_pkg::SFP_OE_NONE;
      end else if (hold_q) begin
         o_lane_oe <= sfp_pkg::SFP_OE_NONE;
      end else if (!drv_q || tx_wait) begin
         o_lane_oe <= sfp_pkg::SFP_OE_NONE;
      end else begin
         tx_cnt_q <= tx_sum[2:0];
         tx_sr_q <= tx_data << step_tx;
         unique case (cur_w)
            sfp_pkg::SFP_QUAD: begin
               o_lane_out <= tx_data[7:4];
               o_lane_oe <= sfp_pkg::SFP_OE_QUAD;
            end
            sfp_pkg::SFP_DUAL: begin
               o_lane_out <= {2'b00, tx_data[7:6]};
               o_lane_oe <= sfp_pkg::SFP_OE_DUAL;
            end
            default: begin
               o_lane_out <= {2'b00, tx_data[7], 1'b0};
               o_lane_oe <= sfp_pkg::SFP_OE_SINGLE;
            end
         endcase
      end
   end

   // One toggle per byte fetched from tx_word_q
   always_ff @(negedge i_sclk or posedge i_reset) begin
      if (i_reset) begin
         take_tgl_q <= 1'b0;
      end else if (!i_cs_n && !hold_q && drv_q && !tx_wait &&
                   tx_cnt_q == sfp_pkg::SFP_CNT_RST) begin
         take_tgl_q <= ~take_tgl_q;
      end
   end

   // Core side synchronisers; first stage feeds only the second
   always_ff @(posedge i_clk or posedge i_reset) begin
      if (i_reset) begin
         // Reset as low: select must really be seen high before arming
         cs_m_q <= 1'b0;
         cs_q <= 1'b0;
         cs_prev_q <= 1'b0;
         wp_m_q <= 1'b1;
         wp_q <= 1'b1;
         pause_m_q <= 1'b0;
         pause_q <= 1'b0;
         rxt_m_q <= 1'b0;
         rxt_q <= 1'b0;
         tkt_m_q <= 1'b0;
         tkt_q <= 1'b0;
      end else if (i_ce) begin
         cs_m_q <= i_cs_n;
         cs_q <= cs_m_q;
         cs_prev_q <= cs_q;
         wp_m_q <= i_lane_in[sfp_pkg::SFP_LANE_PROTECT];
         wp_q <= wp_m_q;
         pause_m_q <= hold_q;
         pause_q <= pause_m_q;
         rxt_m_q <= rx_tgl_q;
         rxt_q <= rxt_m_q;
         tkt_m_q <= take_tgl_q;
         tkt_q <= tkt_m_q;
      end
   end

   assign cs_fall = cs_prev_q & ~cs_q;
   assign cs_rise = ~cs_prev_q & cs_q;

   // Framing: a select fall only counts once select was seen high
   always_ff @(posedge i_clk or posedge i_reset) begin
      if (i_reset) begin
         armed_q <= 1'b0;
         frame_ok_q <= 1'b0;
         o_frame_start <= 1'b0;
         o_frame_end <= 1'b0;
         o_selected <= 1'b0;
      end else if (i_ce) begin
         if (cs_q) begin
            armed_q <= 1'b1;
         end
         if (cs_fall) begin
            frame_ok_q <= armed_q;
         end else if (cs_rise) begin
            frame_ok_q <= 1'b0;
         end
         o_frame_start <= cs_fall & armed_q;
         // Only the command frame ends; a running cycle is left alone
         o_frame_end <= cs_rise & frame_ok_q;
         o_selected <= frame_ok_q & ~cs_q;
      end
   end

   // Byte hand-over in both directions
   always_ff @(posedge i_clk or posedge i_reset) begin
      if (i_reset) begin
         rx_seen_q <= 1'b0;
         tk_seen_q <= 1'b0;
         o_rx_valid <= 1'b0;
         o_rx_byte <= sfp_pkg::SFP_BYTE_RST;
         o_tx_take <= 1'b0;
         tx_word_q <= sfp_pkg::SFP_BYTE_RST;
      end else if (i_ce) begin
         rx_seen_q <= rxt_q;
         tk_seen_q <= tkt_q;
         o_rx_valid <= (rxt_q != rx_seen_q) & frame_ok_q;
         if (rxt_q != rx_seen_q) begin
            o_rx_byte <= rx_buf_q[rx_seen_q];
         end
         o_tx_take <= tkt_q != tk_seen_q;
         if (i_tx_load) begin
            tx_word_q <= i_tx_byte;
         end
      end
   end

   // Protect pin is ignored in quad mode, where it carries data
   always_ff @(posedge i_clk or posedge i_reset) begin
      if (i_reset) begin
         o_paused <= 1'b0;
         o_status_write_block <= 1'b0;
         o_hw_protect_active <= 1'b0;
      end else if (i_ce) begin
         o_paused <= pause_q;
         o_status_write_block <=
            (i_status_protect_bits[sfp_pkg::SFP_SP_PIN] & ~wp_q &
             ~i_quad_enable_bit) |
            i_status_protect_bits[sfp_pkg::SFP_SP_LOCK];
         o_hw_protect_active <= ~wp_q & ~i_quad_enable_bit;
      end
   end

endmodule : sfp_pin_if

/* src/sfp_pkg.sv */
/*
 * Shared constants and types for the serial flash pin front end: lane
 * widths, lane roles, output-enable masks and reset values.
 * Assumes a SystemVerilog tool; nothing here holds state.
 */
package sfp_pkg;

   // Width of one lane group: single, dual or quad
   typedef enum logic [1:0] {
      SFP_SINGLE,
      SFP_DUAL,
      SFP_QUAD
   } sfp_lane_mode_t;

   localparam int SFP_BYTE_W = 8;
   localparam int SFP_LANES = 4;
   localparam int SFP_CNT_W = 3;

   // Bits moved per serial clock edge, one wider than the counter
   localparam logic [3:0] SFP_STEP_SINGLE = 4'h1;
   localparam logic [3:0] SFP_STEP_DUAL = 4'h2;
   localparam logic [3:0] SFP_STEP_QUAD = 4'h4;

   // Lane roles
   localparam int SFP_LANE_DATA_IN = 0;
   localparam int SFP_LANE_DATA_OUT = 1;
   localparam int SFP_LANE_PROTECT = 2;
   localparam int SFP_LANE_PAUSE = 3;

   // Lanes driven while sending
   localparam logic [3:0] SFP_OE_SINGLE = 4'h2;
   localparam logic [3:0] SFP_OE_DUAL = 4'h3;
   localparam logic [3:0] SFP_OE_QUAD = 4'hF;
   localparam logic [3:0] SFP_OE_NONE = 4'h0;

   localparam logic [2:0] SFP_CNT_RST = 3'h0;
   localparam logic [7:0] SFP_BYTE_RST = 8'h00;
   localparam logic [3:0] SFP_LANE_RST = 4'h0;

   // Status protect field: bit 0 arms the protect pin, bit 1 locks always
   localparam int SFP_SP_PIN = 0;
   localparam int SFP_SP_LOCK = 1;

endpackage : sfp_pkg

/* bench/sfp_pin_if_chk.sv */
/* Port assertions for the serial flash pin front end.
   Bound into every sfp_pin_if instance. */
`timescale 1ns/10ps
module sfp_pin_if_chk (
   input wire logic i_clk,
   input wire logic i_reset,
   input wire logic i_sclk,
   input wire logic i_cs_n,
   input wire logic [3:0] i_lane_in,
   input wire logic [3:0] o_lane_out,
   input wire logic [3:0] o_lane_oe,
   input wire logic i_quad_enable_bit,
   input wire logic [1:0] i_status_protect_bits,
   input wire logic o_frame_end,
   input wire logic o_selected,
   input wire logic o_paused,
   input wire logic o_status_write_block,
   input wire logic o_hw_protect_active
);
   logic [3:0] rise_q;
   // Value seen at the rise must survive until the next fall
   always_ff @(posedge i_sclk) rise_q <= o_lane_out;
   a_cs_float: assert property (@(posedge i_clk) disable iff (i_reset)
      i_cs_n |-> o_lane_oe == 4'h0) else $error("lanes driven while idle");
   a_pause_float: assert property (@(posedge i_sclk)
      disable iff (i_reset || i_cs_n) !i_quad_enable_bit && !i_lane_in[3]
      |=> o_lane_oe == 4'h0) else $error("lanes driven in pause");
   a_oe_legal: assert property (@(posedge i_clk) disable iff (i_reset)
      o_lane_oe inside {4'h0, 4'h2, 4'h3} || i_quad_enable_bit
      && o_lane_oe == 4'hF) else $error("bad lane enable set");
   a_out_on_fall: assert property (@(negedge i_sclk)
      disable iff (i_reset || i_cs_n) o_lane_out == rise_q)
      else $error("lane out moved on rise");
   a_frame_end: assert property (@(posedge i_clk) disable iff (i_reset)
      $rose(i_cs_n) && o_selected |-> ##[2:4] o_frame_end)
      else $error("no frame end");
   a_status_lock: assert property (@(posedge i_clk) disable iff (i_reset)
      i_status_protect_bits[1] [*5] |-> o_status_write_block)
      else $error("status not locked");
   a_protect_on: assert property (@(posedge i_clk) disable iff (i_reset)
      (!i_quad_enable_bit && !i_lane_in[2]) [*6] |-> o_hw_protect_active)
      else $error("protect pin ignored");
   a_quad_no_pause: assert property (@(posedge i_clk)
      disable iff (i_reset) i_quad_enable_bit [*5] |-> !o_paused)
      else $error("pause active in quad");
endmodule : sfp_pin_if_chk
bind sfp_pin_if sfp_pin_if_chk chk (.i_clk, .i_reset, .i_sclk, .i_cs_n,
   .i_lane_in, .o_lane_out, .o_lane_oe, .i_quad_enable_bit,
   .i_status_protect_bits, .o_frame_end, .o_selected, .o_paused,
   .o_status_write_block, .o_hw_protect_active);

/* bench/sfp_host_model.sv */
/* Host controller model: serial clock, select and lane drive.
   Expects the device lane values and enables at its inputs. */
`timescale 1ns/10ps
module sfp_host_model (
   input wire logic [3:0] i_lane_out,
   input wire logic [3:0] i_lane_oe,
   output logic o_sclk,
   output logic o_cs_n,
   output logic [3:0] o_lane
);
   logic [3:0] hval = 4'h0;
   logic [3:0] hen = 4'hC;
   logic [3:0] last_q = 4'h0;
   logic [3:0] pin;
   logic quad = 1'b0;
   logic wp_n = 1'b1;
   logic hold_n = 1'b1;
   // Select starts low so the first frame lacks a falling edge
   initial o_sclk = 1'b0;
   initial o_cs_n = 1'b0;
   // Released lanes never keep a stale level
   always @(negedge o_sclk or posedge o_cs_n) last_q <= o_lane;
   always_comb begin
      pin = quad ? hval : {hold_n, wp_n, hval[1:0]};
      for (int i = 0; i < 4; i++)
         o_lane[i] = i_lane_oe[i] ? i_lane_out[i] :
            hen[i] ? pin[i] : ~last_q[i];
   end
   task automatic sel();
      #32 o_cs_n = 1'b0;
      #32;
   endtask : sel
   task automatic desel();
      #32 o_cs_n = 1'b1;
      #32;
   endtask : desel
   task automatic xfer(input int w, input logic drv, input logic [7:0] tx,
                       input logic pz, output logic [7:0] rx);
      logic [7:0] sh;
      sh = tx;
      rx = 8'h00;
      quad = (w == 4);
      hen = {{2{w != 4 || !drv}}, drv ? 2'h0 : 2'(w == 1 ? 1 : 3)};
      for (int k = 0; k < 8 / w; k++) begin
         if (pz && k == 2) begin
            hold_n = 1'b0;
            repeat (3) begin
               #32 o_sclk = 1'b1;
               #32 o_sclk = 1'b0;
            end
            hold_n = 1'b1;
         end
         hval = 4'(sh >> (8 - w));
         sh = sh << w;
         #32 o_sclk = 1'b1;
         rx = (w == 1) ? {rx[6:0], o_lane[1]} :
            8'((rx << w) | (o_lane & 4'(2 ** w - 1)));
         #32 o_sclk = 1'b0;
      end
      quad = 1'b0;
      hen = 4'hC;
   endtask : xfer
endmodule : sfp_host_model

/* bench/testbench.sv */
/* Bench top: clock, reset, host model and core-side stimulus.
   Expects sfp_pin_if, its bound checker and the host model. */
`timescale 1ns/10ps
`define CHK(a, e) begin n_compared++; if ((a) !== (e)) begin fails++; \
   $display("wrong value at %0t: %h, expected %h", $time, a, e); end end
module testbench;
   logic i_clk, i_reset, i_sclk, i_cs_n, i_drive, i_quad_enable_bit;
   logic i_tx_load, o_tx_take, o_rx_valid, o_frame_start, o_paused;
   logic o_status_write_block, o_hw_protect_active, paused_seen = 1'b0;
   logic [3:0] i_lane_in, o_lane_out, o_lane_oe;
   logic [1:0] i_status_protect_bits;
   logic [7:0] i_tx_byte, o_rx_byte, r;
   logic [7:0] rxq[$];
   sfp_pkg::sfp_lane_mode_t i_lane_mode;
   int fails = 0, n_compared = 0, cyc = 0, takes = 0, starts = 0;
   sfp_pin_if dut (.i_clk, .i_reset, .i_ce(1'b1), .i_sclk, .i_cs_n,
      .i_lane_in, .o_lane_out, .o_lane_oe, .i_lane_mode, .i_drive,
      .i_quad_enable_bit, .i_status_protect_bits, .i_tx_byte, .i_tx_load,
      .o_tx_take, .o_rx_valid, .o_rx_byte, .o_frame_start, .o_frame_end(),
      .o_selected(), .o_paused, .o_status_write_block, .o_hw_protect_active);
   sfp_host_model host (.i_lane_out(o_lane_out), .i_lane_oe(o_lane_oe),
      .o_sclk(i_sclk), .o_cs_n(i_cs_n), .o_lane(i_lane_in));
   initial begin
      i_clk = 1'b0;
      forever #25 i_clk = ~i_clk;
   end
   task automatic conclude();
      if (fails == 0 && n_compared > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask : conclude
   always @(posedge i_clk) begin
      cyc++;
      if (o_rx_valid === 1'b1) rxq.push_back(o_rx_byte);
      if (o_tx_take === 1'b1) takes++;
      if (o_frame_start === 1'b1) starts++;
      if (o_paused === 1'b1) paused_seen = 1'b1;
      if (cyc == 5000) begin
         fails++;
         conclude();
      end
   end
   // Command byte in single width, then one data byte in the asked width
   task automatic frame(input int w, input sfp_pkg::sfp_lane_mode_t md,
      input logic qe, input logic drv, input logic [7:0] d, input logic pz);
      @(posedge i_clk);
      #1 i_tx_load = drv;
      i_tx_byte = d;
      i_quad_enable_bit = qe;
      rxq.delete();
      @(posedge i_clk);
      #1 i_tx_load = 1'b0;
      host.sel();
      fork
         host.xfer(1, 1'b0, 8'h3C, pz, r);
         begin
            repeat (4) @(posedge i_clk);
            #1 i_drive = drv;
            i_lane_mode = md;
         end
      join
      host.xfer(w, drv, d, 1'b0, r);
      host.desel();
      repeat (8) @(posedge i_clk);
      #1 i_drive = 1'b0;
      i_lane_mode = sfp_pkg::SFP_SINGLE;
      `CHK(rxq[0], 8'h3C)
      if (drv) `CHK(r, d)
      else `CHK(rxq[1], d)
   endtask : frame
   initial begin
      i_reset = 1'b1;
      i_drive = 1'b0;
      i_tx_load = 1'b0;
      i_tx_byte = 8'h00;
      i_quad_enable_bit = 1'b0;
      i_status_protect_bits = 2'h0;
      i_lane_mode = sfp_pkg::SFP_SINGLE;
      repeat (8) @(posedge i_clk);
      #1 i_reset = 1'b0;
      host.xfer(1, 1'b0, 8'h81, 1'b0, r);
      host.desel();
      repeat (8) @(posedge i_clk);
      `CHK(rxq.size(), 0)
      for (int w = 1; w <= 4; w *= 2)
         for (int d = 0; d < 2; d++)
            frame(w, sfp_pkg::sfp_lane_mode_t'(w / 2), w == 4, d[0],
               8'(8'hA5 + w * 16 + d), 1'b0);
      frame(2, sfp_pkg::SFP_QUAD, 1'b0, 1'b0, 8'h5A, 1'b0);
      frame(2, sfp_pkg::SFP_QUAD, 1'b0, 1'b1, 8'hC3, 1'b0);
      frame(1, sfp_pkg::SFP_SINGLE, 1'b0, 1'b0, 8'h96, 1'b1);
      `CHK(paused_seen, 1'b1)
      host.sel();
      host.xfer(2, 1'b0, 8'hF0, 1'b0, r);
      host.desel();
      frame(1, sfp_pkg::SFP_SINGLE, 1'b0, 1'b0, 8'h69, 1'b0);
      `CHK(rxq.size(), 2)
      `CHK(starts, 11)
      `CHK(takes, 8)
      i_status_protect_bits = 2'h1;
      host.wp_n = 1'b0;
      repeat (8) @(posedge i_clk);
      `CHK(o_hw_protect_active, 1'b1)
      `CHK(o_status_write_block, 1'b1)
      #1 i_quad_enable_bit = 1'b1;
      repeat (8) @(posedge i_clk);
      `CHK(o_hw_protect_active, 1'b0)
      `CHK(o_status_write_block, 1'b0)
      conclude();
   end
endmodule : testbench
